/* design/irq_expander_pkg.sv */
// Constants, register addresses and vector table layout of the interrupt expander.
// Assumes a single 250 MHz clock and a 16-bit word-addressed register port.
//
// Contract
// - Twelve groups of eight lines, one CPU interrupt per group, 96 positions.
// - Only 58 positions carry peripherals; groups 10 and 11 carry none.
// - No reset vector entry; trap 0 while enabled gives an undefined vector.
// - While enabled, trap n from 1 to 12 fetches line 1 of group n.
// - Group 1: sequencers, reserved, pins 1-2, ADC done, timer 0, wake.
// - Group 2: PWM trip-zone 1-6 on lines 1-6, lines 7-8 reserved.
// - Group 3: PWM event 1-6 on lines 1-6, lines 7-8 reserved.
// - Group 4: capture modules 1-6 on lines 1-6, lines 7-8 reserved.
// - Group 5: encoders 1-2 on lines 1-2, lines 3-8 reserved.
// - Group 6: SPI A rx/tx, serial B rx/tx, serial A rx/tx, 7-8 reserved.
// - Group 7: DMA channels 1-6 done on lines 1-6, lines 7-8 reserved.
// - Group 8: I2C 1-2, reserved 3-4, UART C rx/tx 5-6, reserved 7-8.
// - Group 9: UART A and B rx/tx, CAN A lines 0-1, CAN B lines 0-1.
// - Group 12: pins 3-7, reserved, float overflow, float underflow.
// - Software-set enabled flag on a reserved line raises the group interrupt.
// - Control, acknowledge, then enable and flag per group, consecutive addresses.
// - Control registers need no unlock; vector table writes need the unlock.

package irq_expander_pkg;

  localparam int NUM_GROUPS = 12;
  localparam int LINES_PER_GROUP = 8;
  localparam int NUM_LINES = 96;
  localparam int USED_LINES = 58;
  localparam int NUM_EXT_PINS = 7;

  // Register word addresses
  localparam logic [15:0] CTRL_ADDR = 16'h0ce0;
  localparam logic [15:0] ACK_ADDR = 16'h0ce1;
  localparam logic [15:0] GROUP_BASE_ADDR = 16'h0ce2;
  localparam logic [15:0] GROUP_SPAN = 16'h0018;

  // Field positions and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RST = 1'b0;
  localparam logic [11:0] ACK_RST = 12'h000;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] IFR_RST = 8'h00;

  // Vector table: 128 words, groups start at slot 32, slot 0 holds no reset vector
  localparam int VEC_DEPTH = 128;
  localparam logic [6:0] VEC_GROUP_BASE = 7'h20;
  localparam logic [6:0] VEC_RESET_SLOT = 7'h00;
  localparam logic [3:0] TRAP_MIN = 4'h1;
  localparam logic [3:0] TRAP_MAX = 4'hc;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

endpackage : irq_expander_pkg

/* design/pin_sync.sv */
// Three-stage synchroniser for asynchronous pin inputs.
// The output moves only when stages two and three agree.
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] agree;

  assign agree = ~(s2_r ^ s3_r);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      o_sync <= '0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      o_sync <= (agree & s2_r) | (~agree & o_sync);
    end
  end

endmodule : pin_sync

/* design/irq_expander.sv */
// Peripheral interrupt expander: 96 lines in 12 groups onto 12 CPU interrupts,
// with a vector table answering CPU vector fetches and software traps.
// Peripheral lines come from logic on I_CLK; external pins are asynchronous.
`timescale 1ns/1ps

module irq_expander (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Peripheral sources, rising edge sets the flag
  input wire logic I_ADC_SEQUENCER1_IRQ,
  input wire logic I_ADC_SEQUENCER2_IRQ,
  input wire logic I_ADC_DONE_IRQ,
  input wire logic I_CPU_TIMER0_IRQ,
  input wire logic I_WAKE_EVENT_IRQ,
  input wire logic [6:0] I_EXTERNAL_PIN_IRQ,
  input wire logic [5:0] I_PWM_TRIP_ZONE_IRQ,
  input wire logic [5:0] I_PWM_EVENT_IRQ,
  input wire logic [5:0] I_CAPTURE_MODULE_IRQ,
  input wire logic [1:0] I_ENCODER_MODULE_IRQ,
  input wire logic I_SPI_A_RECEIVE_IRQ,
  input wire logic I_SPI_A_TRANSMIT_IRQ,
  input wire logic [1:0] I_BUFFERED_SERIAL_RECEIVE_IRQ,
  input wire logic [1:0] I_BUFFERED_SERIAL_TRANSMIT_IRQ,
  input wire logic [5:0] I_DMA_CHANNEL_DONE_IRQ,
  input wire logic I_I2C_FIRST_IRQ,
  input wire logic I_I2C_SECOND_IRQ,
  input wire logic [2:0] I_UART_RECEIVE_IRQ,
  input wire logic [2:0] I_UART_TRANSMIT_IRQ,
  input wire logic [1:0] I_CAN_LINE0_IRQ,
  input wire logic [1:0] I_CAN_LINE1_IRQ,
  input wire logic I_FLOAT_OVERFLOW_FLAG,
  input wire logic I_FLOAT_UNDERFLOW_FLAG,
  // Register port, word addressed
  input wire logic [15:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [15:0] I_REG_WDATA,
  output logic [15:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  // Vector table write port
  input wire logic I_PROT_UNLOCK,
  input wire logic I_VEC_WR,
  input wire logic [6:0] I_VEC_INDEX,
  input wire logic [31:0] I_VEC_WDATA,
  // CPU side
  output logic [11:0] O_CPU_INT,
  input wire logic I_INT_FETCH,
  input wire logic [3:0] I_FETCH_GROUP,
  input wire logic I_TRAP,
  input wire logic [3:0] I_TRAP_NUM,
  output logic O_VEC_VALID,
  output logic [31:0] O_VEC_DATA,
  output logic [6:0] O_VEC_SLOT,
  output logic O_EXPANDER_ENABLED
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [6:0] vec_index(input logic [3:0] grp0, input logic [2:0] line0);
    vec_index = irq_expander_pkg::VEC_GROUP_BASE + {grp0, line0};
  endfunction : vec_index

  function automatic logic [2:0] first_line(input logic [7:0] pend);
    first_line = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (pend[i]) begin
        first_line = 3'(i);
      end
    end
  endfunction : first_line

  ////////////////////////////////////////////////////////////////////////////
  // Source mapping

  logic [6:0] pin_sync_lvl;
  logic [95:0] src;
  logic [95:0] src_prev_r;
  logic [95:0] rise;

  pin_sync #(
    .WIDTH(irq_expander_pkg::NUM_EXT_PINS)
  ) u_pin_sync (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_async(I_EXTERNAL_PIN_IRQ),
    .o_sync(pin_sync_lvl)
  );

  // Group 1
  assign src[7:0] = {I_WAKE_EVENT_IRQ, I_CPU_TIMER0_IRQ, I_ADC_DONE_IRQ, pin_sync_lvl[1:0],
                     1'b0, I_ADC_SEQUENCER2_IRQ, I_ADC_SEQUENCER1_IRQ};
  assign src[15:8] = {2'h0, I_PWM_TRIP_ZONE_IRQ};
  assign src[23:16] = {2'h0, I_PWM_EVENT_IRQ};
  assign src[31:24] = {2'h0, I_CAPTURE_MODULE_IRQ};
  assign src[39:32] = {6'h00, I_ENCODER_MODULE_IRQ};
  assign src[47:40] = {2'h0, I_BUFFERED_SERIAL_TRANSMIT_IRQ[0], I_BUFFERED_SERIAL_RECEIVE_IRQ[0],
                       I_BUFFERED_SERIAL_TRANSMIT_IRQ[1], I_BUFFERED_SERIAL_RECEIVE_IRQ[1],
                       I_SPI_A_TRANSMIT_IRQ, I_SPI_A_RECEIVE_IRQ};
  assign src[55:48] = {2'h0, I_DMA_CHANNEL_DONE_IRQ};
  assign src[63:56] = {2'h0, I_UART_TRANSMIT_IRQ[2], I_UART_RECEIVE_IRQ[2], 2'h0,
                       I_I2C_SECOND_IRQ, I_I2C_FIRST_IRQ};
  assign src[71:64] = {I_CAN_LINE1_IRQ[1], I_CAN_LINE0_IRQ[1], I_CAN_LINE1_IRQ[0], I_CAN_LINE0_IRQ[0],
                       I_UART_TRANSMIT_IRQ[1], I_UART_RECEIVE_IRQ[1],
                       I_UART_TRANSMIT_IRQ[0], I_UART_RECEIVE_IRQ[0]};
  // Groups 10 and 11 have only reserved lines
  assign src[87:72] = 16'h0000;
  assign src[95:88] = {I_FLOAT_UNDERFLOW_FLAG, I_FLOAT_OVERFLOW_FLAG, 1'b0, pin_sync_lvl[6:2]};

  assign rise = src & ~src_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic enable_r;
  logic [11:0] ack_r;
  logic [95:0] ier_r;
  logic [95:0] ifr_r;

  logic [15:0] grp_off;
  logic in_groups;
  logic [3:0] acc_grp;
  logic acc_flag;
  logic wr_ctrl;
  logic wr_ack;

  assign grp_off = I_REG_ADDR - irq_expander_pkg::GROUP_BASE_ADDR;
  assign in_groups = (I_REG_ADDR >= irq_expander_pkg::GROUP_BASE_ADDR) &&
                     (grp_off < irq_expander_pkg::GROUP_SPAN);
  assign acc_grp = grp_off[4:1];
  assign acc_flag = grp_off[0];
  // No unlock needed for these registers
  assign wr_ctrl = I_REG_WR && (I_REG_ADDR == irq_expander_pkg::CTRL_ADDR);
  assign wr_ack = I_REG_WR && (I_REG_ADDR == irq_expander_pkg::ACK_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Vector fetch and trap

  logic fetch_grp_ok;
  logic [3:0] fetch_grp0;
  logic [7:0] fetch_pend;
  logic [2:0] fetch_line;
  logic fetch_take;
  logic [95:0] fetch_clr;
  logic [11:0] ack_set;
  logic trap_take;
  logic trap_num_ok;
  logic [6:0] trap_slot;
  logic [6:0] answer_slot;
  logic answer_take;

  assign fetch_grp_ok = (I_FETCH_GROUP >= irq_expander_pkg::TRAP_MIN) &&
                        (I_FETCH_GROUP <= irq_expander_pkg::TRAP_MAX);
  assign fetch_grp0 = I_FETCH_GROUP - 4'h1;
  assign fetch_pend = fetch_grp_ok ? (ifr_r[{fetch_grp0, 3'h0} +: 8] & ier_r[{fetch_grp0, 3'h0} +: 8]) : 8'h00;
  assign fetch_line = first_line(fetch_pend);
  assign fetch_take = I_INT_FETCH && enable_r && (fetch_pend != 8'h00);
  // Fetch clears the chosen flag and blocks its group until acknowledged
  assign fetch_clr = fetch_take ? (96'h1 << {fetch_grp0, fetch_line}) : 96'h0;
  assign ack_set = fetch_take ? (12'h001 << fetch_grp0) : 12'h000;

  assign trap_take = I_TRAP && enable_r && !fetch_take;
  assign trap_num_ok = (I_TRAP_NUM >= irq_expander_pkg::TRAP_MIN) &&
                       (I_TRAP_NUM <= irq_expander_pkg::TRAP_MAX);
  // Trap 0 lands on a slot that holds no reset vector
  assign trap_slot = trap_num_ok ? vec_index(I_TRAP_NUM - 4'h1, 3'h0)
                                 : irq_expander_pkg::VEC_RESET_SLOT;
  assign answer_slot = fetch_take ? vec_index(fetch_grp0, fetch_line) : trap_slot;
  assign answer_take = fetch_take || trap_take;

  ////////////////////////////////////////////////////////////////////////////
  // Group flag, enable and acknowledge state

  logic [95:0] ifr_nxt;
  logic [95:0] ier_nxt;
  logic [11:0] ack_nxt;

  for (genvar g = 0; g < irq_expander_pkg::NUM_GROUPS; g++) begin : g_grp
    logic wr_ier_g;
    logic wr_ifr_g;
    logic [7:0] ifr_base;

    assign wr_ier_g = I_REG_WR && in_groups && !acc_flag && (acc_grp == 4'(g));
    assign wr_ifr_g = I_REG_WR && in_groups && acc_flag && (acc_grp == 4'(g));
    // A software write replaces the whole flag byte, peripheral bits included
    assign ifr_base = wr_ifr_g ? I_REG_WDATA[7:0] : ifr_r[g*8 +: 8];
    // New edges win over both the write and the fetch clear
    assign ifr_nxt[g*8 +: 8] = (ifr_base & ~fetch_clr[g*8 +: 8]) | rise[g*8 +: 8];
    assign ier_nxt[g*8 +: 8] = wr_ier_g ? I_REG_WDATA[7:0] : ier_r[g*8 +: 8];
    // Group interrupt: enabled, not waiting for acknowledge, some enabled flag set
    assign O_CPU_INT[g] = enable_r && !ack_r[g] &&
                          ((ifr_r[g*8 +: 8] & ier_r[g*8 +: 8]) != 8'h00);
  end

  // Writing one releases a group; a fetch in the same cycle keeps it held
  assign ack_nxt = (ack_r & ~(wr_ack ? I_REG_WDATA[11:0] : 12'h000)) | ack_set;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [15:0] rdata_nxt;
  logic [7:0] rd_ier;
  logic [7:0] rd_ifr;

  assign rd_ier = ier_r[{acc_grp, 3'h0} +: 8];
  assign rd_ifr = ifr_r[{acc_grp, 3'h0} +: 8];
  assign rdata_nxt = (I_REG_ADDR == irq_expander_pkg::CTRL_ADDR) ? {15'h0000, enable_r} :
                     (I_REG_ADDR == irq_expander_pkg::ACK_ADDR) ? {4'h0, ack_r} :
                     in_groups ? {8'h00, acc_flag ? rd_ifr : rd_ier} : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Vector table, writable only while unlocked

  logic [31:0] vec_mem [irq_expander_pkg::VEC_DEPTH];

  always_ff @(posedge I_CLK) begin
    if (I_VEC_WR && I_PROT_UNLOCK) begin
      vec_mem[I_VEC_INDEX] <= I_VEC_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  logic enable_nxt;

  // Enable is the only writable control field
  assign enable_nxt = wr_ctrl ? I_REG_WDATA[irq_expander_pkg::CTRL_ENABLE_BIT] : enable_r;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      enable_r <= irq_expander_pkg::CTRL_ENABLE_RST;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ack_r <= irq_expander_pkg::ACK_RST;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ier_r <= {irq_expander_pkg::NUM_GROUPS{irq_expander_pkg::IER_RST}};
    end else begin
      ier_r <= ier_nxt;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ifr_r <= {irq_expander_pkg::NUM_GROUPS{irq_expander_pkg::IFR_RST}};
    end else begin
      ifr_r <= ifr_nxt;
    end
  end

  // Previous source levels feed the rising-edge detector
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      src_prev_r <= 96'h0;
    end else begin
      src_prev_r <= src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_REG_RDATA <= 16'h0000;
      O_REG_RVALID <= 1'b0;
    end else begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD) begin
        O_REG_RDATA <= rdata_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector answer to the CPU

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_VEC_VALID <= 1'b0;
      O_VEC_DATA <= 32'h0000_0000;
      O_VEC_SLOT <= 7'h00;
    end else begin
      O_VEC_VALID <= answer_take;
      if (answer_take) begin
        O_VEC_DATA <= vec_mem[answer_slot];
        O_VEC_SLOT <= answer_slot;
      end
    end
  end

  assign O_EXPANDER_ENABLED = enable_r;

endmodule : irq_expander

/* sim/irq_expander_asserts.sv */
// Concurrent checks on the ports of the interrupt expander.
// Assumes one clock domain; bound to every irq_expander instance.
`timescale 1ns/1ps

module irq_expander_asserts (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [15:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic O_REG_RVALID,
  input wire logic [11:0] O_CPU_INT,
  input wire logic I_INT_FETCH,
  input wire logic [3:0] I_FETCH_GROUP,
  input wire logic I_TRAP,
  input wire logic [3:0] I_TRAP_NUM,
  input wire logic O_VEC_VALID,
  input wire logic [6:0] O_VEC_SLOT,
  input wire logic O_EXPANDER_ENABLED
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  logic trap_go;
  logic fetch_go;
  logic [3:0] g_m1;
  assign trap_go = I_TRAP && !I_INT_FETCH && O_EXPANDER_ENABLED;
  assign g_m1 = I_FETCH_GROUP - 4'h1;
  // A raised group line guarantees that the fetch is taken
  assign fetch_go = I_INT_FETCH && O_EXPANDER_ENABLED && (I_FETCH_GROUP inside {[1:12]}) && O_CPU_INT[g_m1];
  sequence s_fetch;
    fetch_go;
  endsequence
  sequence s_answer;
    O_VEC_VALID ##0 O_VEC_SLOT[6:3] == $past(I_FETCH_GROUP) + 4'h3;
  endsequence
  property p_rd_answer;
    I_REG_RD |=> O_REG_RVALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_quiet;
    !I_REG_RD |=> !O_REG_RVALID;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read valid without read");
  property p_fetch_slot;
    s_fetch |=> s_answer;
  endproperty
  a_fetch_slot: assert property (p_fetch_slot) else $error("fetch slot wrong");
  property p_fetch_drop;
    s_fetch ##1 !I_REG_WR |-> !O_CPU_INT[$past(g_m1)] ##1 !O_CPU_INT[$past(g_m1, 2)];
  endproperty
  a_fetch_drop: assert property (p_fetch_drop) else $error("group line not held off");
  property p_trap_slot;
    trap_go && (I_TRAP_NUM inside {[1:12]}) |=> O_VEC_VALID && O_VEC_SLOT == 7'h20 + {$past(I_TRAP_NUM) - 4'h1, 3'b000};
  endproperty
  a_trap_slot: assert property (p_trap_slot) else $error("trap slot wrong");
  property p_trap_zero;
    trap_go && !(I_TRAP_NUM inside {[1:12]}) |=> O_VEC_VALID && O_VEC_SLOT == 7'h00;
  endproperty
  a_trap_zero: assert property (p_trap_zero) else $error("trap zero slot wrong");
  property p_no_req;
    !((I_INT_FETCH || I_TRAP) && O_EXPANDER_ENABLED) |=> !O_VEC_VALID;
  endproperty
  a_no_req: assert property (p_no_req) else $error("vector without request");
  property p_ctrl_wr;
    I_REG_WR && I_REG_ADDR == irq_expander_pkg::CTRL_ADDR |=> O_EXPANDER_ENABLED == $past(I_REG_WDATA[0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");
endmodule : irq_expander_asserts

bind irq_expander irq_expander_asserts chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_REG_ADDR(I_REG_ADDR),
  .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_REG_WDATA(I_REG_WDATA), .O_REG_RVALID(O_REG_RVALID),
  .O_CPU_INT(O_CPU_INT), .I_INT_FETCH(I_INT_FETCH), .I_FETCH_GROUP(I_FETCH_GROUP), .I_TRAP(I_TRAP),
  .I_TRAP_NUM(I_TRAP_NUM), .O_VEC_VALID(O_VEC_VALID), .O_VEC_SLOT(O_VEC_SLOT), .O_EXPANDER_ENABLED(O_EXPANDER_ENABLED));

/* sim/cpu_core_model.sv */
// Behavioural CPU core: takes group interrupts by vector fetch and issues traps.
// Assumes the expander's CPU-side ports on the same clock.
`timescale 1ns/1ps

module cpu_core_model (
  input wire logic i_clk,
  input wire logic [11:0] i_cpu_int,
  output logic o_int_fetch,
  output logic [3:0] o_fetch_group,
  output logic o_trap,
  output logic [3:0] o_trap_num
);
  initial begin
    o_int_fetch = 1'b0;
    o_fetch_group = 4'h0;
    o_trap = 1'b0;
    o_trap_num = 4'h0;
  end
  // Fetches only a group whose line is raised; released lines show the inverse
  task automatic take(input logic [3:0] g, input int lag, output logic ok);
    repeat (lag) @(posedge i_clk);
    @(negedge i_clk);
    ok = i_cpu_int[g - 4'h1] === 1'b1;
    if (ok) begin
      @(posedge i_clk);
      o_int_fetch <= 1'b1;
      o_fetch_group <= g;
      @(posedge i_clk);
      o_int_fetch <= 1'b0;
      o_fetch_group <= ~g;
    end
  endtask : take
  task automatic trap(input logic [3:0] n);
    @(posedge i_clk);
    o_trap <= 1'b1;
    o_trap_num <= n;
    @(posedge i_clk);
    o_trap <= 1'b0;
    o_trap_num <= ~n;
  endtask : trap
endmodule : cpu_core_model

/* sim/tb.sv */
// Self-checking bench for the interrupt expander with a CPU core model.
// Assumes the design package, the checker and the core model compile first.
`timescale 1ns/1ps

module tb;
  logic I_CLK;
  logic I_SYS_RST;
  logic [95:0] src;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr;
  logic rd;
  logic rvalid;
  logic unlock;
  logic vwr;
  logic [6:0] vidx;
  logic [31:0] vdata;
  logic [11:0] cpu_int;
  logic fetch;
  logic trap;
  logic vvalid;
  logic enabled;
  logic [3:0] fgrp;
  logic [3:0] tnum;
  logic [31:0] vec;
  logic [6:0] slot;
  int num_errors = 0;
  int n_tests = 0;
  localparam logic [7:0] USED [12] = '{8'hfb, 8'h3f, 8'h3f, 8'h3f, 8'h03, 8'h3f, 8'h3f, 8'h33, 8'hff, 8'h00, 8'h00, 8'hdf};
  irq_expander dut (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .I_ADC_SEQUENCER1_IRQ(src[0]), .I_ADC_SEQUENCER2_IRQ(src[1]), .I_ADC_DONE_IRQ(src[5]),
    .I_CPU_TIMER0_IRQ(src[6]), .I_WAKE_EVENT_IRQ(src[7]), .I_EXTERNAL_PIN_IRQ({src[92:88], src[4:3]}),
    .I_PWM_TRIP_ZONE_IRQ(src[13:8]), .I_PWM_EVENT_IRQ(src[21:16]), .I_CAPTURE_MODULE_IRQ(src[29:24]),
    .I_ENCODER_MODULE_IRQ(src[33:32]), .I_SPI_A_RECEIVE_IRQ(src[40]), .I_SPI_A_TRANSMIT_IRQ(src[41]),
    .I_BUFFERED_SERIAL_RECEIVE_IRQ({src[42], src[44]}), .I_BUFFERED_SERIAL_TRANSMIT_IRQ({src[43], src[45]}),
    .I_DMA_CHANNEL_DONE_IRQ(src[53:48]), .I_I2C_FIRST_IRQ(src[56]), .I_I2C_SECOND_IRQ(src[57]),
    .I_UART_RECEIVE_IRQ({src[60], src[66], src[64]}), .I_UART_TRANSMIT_IRQ({src[61], src[67], src[65]}),
    .I_CAN_LINE0_IRQ({src[70], src[68]}), .I_CAN_LINE1_IRQ({src[71], src[69]}),
    .I_FLOAT_OVERFLOW_FLAG(src[94]), .I_FLOAT_UNDERFLOW_FLAG(src[95]),
    .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
    .O_REG_RVALID(rvalid), .I_PROT_UNLOCK(unlock), .I_VEC_WR(vwr), .I_VEC_INDEX(vidx), .I_VEC_WDATA(vdata),
    .O_CPU_INT(cpu_int), .I_INT_FETCH(fetch), .I_FETCH_GROUP(fgrp), .I_TRAP(trap), .I_TRAP_NUM(tnum),
    .O_VEC_VALID(vvalid), .O_VEC_DATA(vec), .O_VEC_SLOT(slot), .O_EXPANDER_ENABLED(enabled));
  cpu_core_model cpu (.i_clk(I_CLK), .i_cpu_int(cpu_int), .o_int_fetch(fetch), .o_fetch_group(fgrp),
    .o_trap(trap), .o_trap_num(tnum));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  function automatic logic [31:0] vv(input logic [6:0] i);
    return {25'h15a5a5a, i};
  endfunction : vv
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge I_CLK);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge I_CLK);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_chk(input logic [15:0] a, input logic [15:0] e);
    @(posedge I_CLK);
    addr <= a;
    rd <= 1'b1;
    @(posedge I_CLK);
    rd <= 1'b0;
    @(negedge I_CLK);
    check("read valid", 32'(rvalid), 32'h1);
    check("read data", 32'(rdata), 32'(e));
  endtask : reg_chk
  task automatic vec_wr(input logic [6:0] i, input logic [31:0] d, input logic u);
    @(posedge I_CLK);
    vidx <= i;
    vdata <= d;
    vwr <= 1'b1;
    unlock <= u;
    @(posedge I_CLK);
    vwr <= 1'b0;
    unlock <= 1'b0;
  endtask : vec_wr
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    for (int k = 0; k < 27; k++) begin
      reg_chk(irq_expander_pkg::CTRL_ADDR + 16'(k), 16'h0000);
    end
    reg_wr(16'h0cf8, 16'hffa5);
    reg_chk(16'h0cf8, 16'h00a5);
    reg_wr(16'h0cfa, 16'hffff);
    reg_chk(16'h0cfa, 16'h0000);
    reg_wr(16'h0cf8, 16'h0000);
  endtask : t_regs
  task automatic t_traps;
    for (int i = 32; i < 128; i++) begin
      vec_wr(7'(i), vv(7'(i)), 1'b1);
    end
    // Locked write must leave the slot that trap 2 reads untouched
    vec_wr(7'h28, 32'h0, 1'b0);
    cpu.trap(4'h1);
    @(negedge I_CLK);
    check("trap while off", 32'(vvalid), 32'h0);
    reg_wr(irq_expander_pkg::CTRL_ADDR, 16'h0001);
    @(negedge I_CLK);
    check("enabled", 32'(enabled), 32'h1);
    for (int n = 0; n < 14; n++) begin
      cpu.trap(4'(n));
      @(negedge I_CLK);
      check("trap valid", 32'(vvalid), 32'h1);
      check("trap slot", 32'(slot), (n inside {[1:12]}) ? 32'(32 + (n - 1) * 8) : 32'h0);
      if (n inside {[1:12]}) check("trap vector", vec, vv(7'(32 + (n - 1) * 8)));
    end
  endtask : t_traps
  task automatic t_map;
    logic ok;
    int g;
    for (int k = 0; k < 96; k++) begin
      g = k / 8;
      if (k % 8 == 0) reg_wr(irq_expander_pkg::GROUP_BASE_ADDR + 16'(2 * g), 16'h00ff);
      @(posedge I_CLK);
      src[k] <= 1'b1;
      repeat (6) @(posedge I_CLK);
      src[k] <= 1'b0;
      reg_chk(16'h0ce3 + 16'(2 * g), {8'h00, USED[g] & (8'h01 << (k % 8))});
      check("group line", 32'(cpu_int[g]), 32'(USED[g][k % 8]));
      if (USED[g][k % 8]) begin
        cpu.take(4'(g + 1), k % 3, ok);
        check("fetch taken", 32'(ok), 32'h1);
        @(negedge I_CLK);
        check("fetch slot", 32'(slot), 32'(32 + k));
        check("fetch vector", vec, vv(7'(32 + k)));
        reg_chk(16'h0ce3 + 16'(2 * g), 16'h0000);
        reg_wr(irq_expander_pkg::ACK_ADDR, 16'(1 << g));
      end
    end
  endtask : t_map
  task automatic t_soft;
    logic ok;
    // Group 11 has no peripheral, so software may use its lines
    reg_wr(16'h0cf6, 16'h0010);
    reg_wr(16'h0cf7, 16'h0008);
    @(negedge I_CLK);
    check("disabled soft line", 32'(cpu_int[10]), 32'h0);
    reg_wr(16'h0cf7, 16'h0010);
    reg_chk(16'h0cf7, 16'h0010);
    check("soft line", 32'(cpu_int[10]), 32'h1);
    cpu.take(4'hb, 2, ok);
    check("soft fetch taken", 32'(ok), 32'h1);
    @(negedge I_CLK);
    check("soft slot", 32'(slot), 32'h74);
    reg_wr(16'h0cf7, 16'h0010);
    @(negedge I_CLK);
    check("awaiting ack", 32'(cpu_int[10]), 32'h0);
    reg_wr(irq_expander_pkg::ACK_ADDR, 16'h0400);
    @(negedge I_CLK);
    check("after ack", 32'(cpu_int[10]), 32'h1);
  endtask : t_soft
  ////////////////////////////////////////////////////////////////
  initial begin
    I_CLK = 1'b0;
    forever #2 I_CLK = ~I_CLK;
  end
  initial begin
    I_SYS_RST = 1'b1;
    src = '0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    unlock = 1'b0;
    vwr = 1'b0;
    vidx = '0;
    vdata = '0;
    repeat (10) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    t_regs();
    t_traps();
    t_map();
    t_soft();
    complete_run();
  end
  // Run needs under 5000 cycles; the limit is about ten times that
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule : tb
